// >>> rtl/pdt_pkg.sv
// Package: register map, field positions, reset values and types for the PWM dead-time and pin block
package pdt_pkg;

  // ---------------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] PDT_PRESCALE_COUNT_ADDR = 8'hE5;
  localparam logic [7:0] PDT_EDGE_ENABLE_ADDR    = 8'hE6;
  localparam logic [7:0] PDT_OUT_MODE_BRAKE_ADDR = 8'hE7;
  localparam logic [7:0] PDT_OPTION_ADDR         = 8'hF0;
  localparam logic [7:0] PDT_IRQ_STATUS_ADDR     = 8'hF1;
  localparam logic [7:0] PDT_IRQ_ENABLE_ADDR     = 8'hF2;
  localparam logic [7:0] PDT_IRQ_CLEAR_ADDR      = 8'hF3;

  // ---------------------------------------------------------------------------
  // Reset values and field positions
  // ---------------------------------------------------------------------------
  localparam logic [7:0] PDT_EDGE_ENABLE_RST    = 8'h00;
  localparam logic [7:0] PDT_PRESCALE_COUNT_RST = 8'h00;
  localparam logic [3:0] PDT_OUT_MODE_RST       = 4'h0;
  localparam logic [1:0] PDT_OPTION_RST         = 2'h0;
  localparam int         PDT_EDGE_LSB           = 4;
  localparam int         PDT_MODE_LSB           = 4;
  localparam int         PDT_BRAKE_BIT          = 0;
  localparam int         PDT_PRESC_LSB          = 6;
  localparam int         PDT_PAIRS              = 4;
  localparam int         PDT_CHANS              = 8;
  localparam logic [3:0] PDT_PRESC_RST          = 4'h0;

  // Interrupt status bits
  localparam int PDT_IRQ_BRAKE = 0;
  localparam int PDT_IRQ_DT    = 1;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] edge_fall;
    logic [3:0] dt_en;
  } pdt_edge_enable_t;

  typedef struct packed {
    logic [1:0] presc_sel;
    logic [5:0] dt_count;
  } pdt_prescale_count_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pdt_bus_req_t;

  typedef enum logic [1:0] {
    PDT_ST_IDLE  = 2'b00,
    PDT_ST_DELAY = 2'b01,
    PDT_ST_ON    = 2'b10
  } pdt_state_t;

endpackage : pdt_pkg

// >>> rtl/pdt_prescaler.sv
// Dead-time clock prescaler: one-cycle enable at oscillator / 2, 4, 8 or 16
`timescale 1ns/1ps
module pdt_prescaler
  import pdt_pkg::*;
(
  // Clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  // Control
  input  wire logic [1:0] i_sel,
  // Enable out
  output logic            o_tick
);

  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  wire  [3:0] limit = 4'((5'd2 << i_sel) - 5'd1);
  wire        wrap  = (cnt_reg >= limit);

  assign cnt_next = wrap ? PDT_PRESC_RST : cnt_reg + 4'h1;
  assign o_tick   = wrap;

  always_ff @(posedge i_mclk) begin
    if (i_rst) cnt_reg <= PDT_PRESC_RST;
    else       cnt_reg <= cnt_next;
  end

  tick_period_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_tick && i_sel == 2'b00 ##1 i_sel == 2'b00 [*2] |-> o_tick && !$past(o_tick))
    else $error("prescaler divide by two wrong");

endmodule : pdt_prescaler

// >>> rtl/pdt_pair.sv
// One complementary pair with optional dead-time insertion on a chosen edge
`timescale 1ns/1ps
module pdt_pair
  import pdt_pkg::*;
(
  // Clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  // Control
  input  wire logic       i_tick,
  input  wire logic       i_active,
  input  wire logic       i_edge_fall,
  input  wire logic [5:0] i_count,
  // Comparator level
  input  wire logic       i_cmp,
  // Pair outputs
  output logic            o_even,
  output logic            o_odd
);

  pdt_state_t st_reg;
  pdt_state_t st_next;
  logic [6:0] cnt_reg;
  logic [6:0] cnt_next;
  logic       even_reg;
  logic       odd_reg;

  // Edge chosen for the delay: rising of comparator or falling of it
  wire        src     = i_edge_fall ? ~i_cmp : i_cmp;
  wire        done    = i_tick && (cnt_reg == 7'(i_count));

  always_comb begin
    st_next  = st_reg;
    cnt_next = cnt_reg;
    case (st_reg)
      PDT_ST_IDLE: begin
        cnt_next = 7'd0;
        if (src) st_next = PDT_ST_DELAY;
      end
      PDT_ST_DELAY: begin
        if (!src) st_next = PDT_ST_IDLE;
        else if (done) st_next = PDT_ST_ON;
        else if (i_tick) cnt_next = cnt_reg + 7'd1;
      end
      PDT_ST_ON: begin
        if (!src) st_next = PDT_ST_IDLE;
      end
      default: st_next = PDT_ST_IDLE;
    endcase
  end

  // On the chosen edge the falling output follows at once; the rising one waits out the dead time
  wire on_lvl = (st_reg == PDT_ST_ON) && src;
  wire a_lvl  = i_edge_fall ? ~src : on_lvl;
  wire b_lvl  = i_edge_fall ? on_lvl : ~src;
  wire even_n = i_active ? a_lvl : i_cmp;
  wire odd_n  = i_active ? b_lvl : ~i_cmp;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      st_reg   <= PDT_ST_IDLE;
      cnt_reg  <= 7'd0;
      even_reg <= 1'b0;
      odd_reg  <= 1'b1;
    end else begin
      st_reg   <= st_next;
      cnt_reg  <= cnt_next;
      even_reg <= even_n;
      odd_reg  <= odd_n;
    end
  end

  assign o_even = even_reg;
  assign o_odd  = odd_reg;

  no_overlap_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_active |=> !(o_even && o_odd))
    else $error("pair outputs overlap during dead time");
  plain_compl_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    !i_active |=> (o_even == $past(i_cmp)) && (o_odd == !$past(i_cmp)))
    else $error("pair outputs not complementary");

endmodule : pdt_pair

// >>> rtl/pdt_top.sv
// PWM dead-time insertion, output-mode pin gating and external brake flag
//
// How it works
// - Bits 7-4 pick falling or rising delay edge.
// - Bits 3-0 enable dead time per pair.
// - Dead time only in complementary pair mode.
// - Inactive insertion gives exact undelayed complements.
// - Enabled insertion delays only the low-to-high transition on the chosen edge.
// - Edge and enable fields reset to zero.
// - Mode bit 7 gates channels 0, 2, 4.
// - Mode bit 6 gates channels 1, 3, 5.
// - Bits 5 and 4 gate channels 6, 7.
// - Brake pin sets flag until software clears.
// - Option, mode, latch choose pin structure internally.
// - External execution forces push-pull memory access.
// - Reset clears mode bits; pins start tri-stated.
// - Dead-time clock is oscillator over 2..16.
// - Dead time lasts count plus one ticks.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
module pdt_top
  import pdt_pkg::*;
(
  // Clock and reset
  input  wire logic                 i_mclk,
  input  wire logic                 i_rst,
  // Register port
  input  wire logic [7:0]           i_addr,
  input  wire logic [7:0]           i_wdata,
  input  wire logic                 i_wr,
  input  wire logic                 i_rd,
  output logic      [7:0]           o_rdata,
  // PWM sources and pair mode
  input  wire logic [PDT_CHANS-1:0] i_pwm_cmp,
  input  wire logic [PDT_PAIRS-1:0] i_pair_compl,
  // System state
  input  wire logic                 i_ext_exec,
  input  wire logic                 i_ext_data_out,
  input  wire logic [PDT_CHANS-1:0] i_ext_addr_out,
  input  wire logic [PDT_CHANS-1:0] i_port_latch_bit,
  input  wire logic                 i_brake_pin,
  // Pins
  output logic      [PDT_CHANS-1:0] o_pin_out,
  output logic      [PDT_CHANS-1:0] o_pin_oe,
  output logic      [PDT_CHANS-1:0] o_pin_pullup,
  output logic      [PDT_CHANS-1:0] o_pin_strong,
  // Interrupt
  output logic                      o_irq
);

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  pdt_edge_enable_t    deadtime_edge_enable_reg;
  pdt_prescale_count_t deadtime_prescale_count_reg;
  logic [3:0]          out_mode_reg;
  logic                brake_flag_reg;
  logic [1:0]          option_reg;
  logic [1:0]          irq_status_reg;
  logic [1:0]          irq_enable_reg;
  logic [7:0]          rdata_reg;
  logic                brake_prev_reg;
  logic [1:0]          irq_status_next;
  logic                brake_flag_next;

  pdt_bus_req_t req;
  assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  // ---------------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------------
  function automatic logic hit(input pdt_bus_req_t r, input logic [7:0] a);
    hit = (r.addr == a);
  endfunction : hit

  wire wr_pc   = req.wr && hit(req, PDT_PRESCALE_COUNT_ADDR);
  wire wr_ee   = req.wr && hit(req, PDT_EDGE_ENABLE_ADDR);
  wire wr_mb   = req.wr && hit(req, PDT_OUT_MODE_BRAKE_ADDR);
  wire wr_opt  = req.wr && hit(req, PDT_OPTION_ADDR);
  wire wr_ien  = req.wr && hit(req, PDT_IRQ_ENABLE_ADDR);
  wire wr_iclr = req.wr && hit(req, PDT_IRQ_CLEAR_ADDR);

  // ---------------------------------------------------------------------------
  // Events
  // ---------------------------------------------------------------------------
  wire brake_evt = i_brake_pin && !brake_prev_reg;
  wire [PDT_PAIRS-1:0] dt_on = deadtime_edge_enable_reg.dt_en & i_pair_compl;
  wire dt_cfg_evt = wr_ee && (|(req.wdata[3:0] & i_pair_compl));

  // Set beats the software clear in the same cycle
  assign brake_flag_next = (i_brake_pin) ? 1'b1 :
                           (wr_mb && !req.wdata[PDT_BRAKE_BIT]) ? 1'b0 :
                           brake_flag_reg;
  assign irq_status_next = (irq_status_reg & ~(wr_iclr ? req.wdata[1:0] : 2'b00))
                           | {dt_cfg_evt, brake_evt};

  // ---------------------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------------------
  wire [7:0] rd_mux =
    hit(req, PDT_PRESCALE_COUNT_ADDR) ? deadtime_prescale_count_reg :
    hit(req, PDT_EDGE_ENABLE_ADDR)    ? deadtime_edge_enable_reg :
    hit(req, PDT_OUT_MODE_BRAKE_ADDR) ? {out_mode_reg, 3'b000, brake_flag_reg} :
    hit(req, PDT_OPTION_ADDR)         ? {6'h00, option_reg} :
    hit(req, PDT_IRQ_STATUS_ADDR)     ? {6'h00, irq_status_reg} :
    hit(req, PDT_IRQ_ENABLE_ADDR)     ? {6'h00, irq_enable_reg} :
    8'h00;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      deadtime_edge_enable_reg    <= PDT_EDGE_ENABLE_RST;
      deadtime_prescale_count_reg <= PDT_PRESCALE_COUNT_RST;
      out_mode_reg                <= PDT_OUT_MODE_RST;
      option_reg                  <= PDT_OPTION_RST;
      brake_flag_reg              <= 1'b0;
      brake_prev_reg              <= 1'b0;
      irq_status_reg              <= 2'b00;
      irq_enable_reg              <= 2'b00;
      rdata_reg                   <= 8'h00;
    end else begin
      if (wr_pc)  deadtime_prescale_count_reg <= req.wdata;
      if (wr_ee)  deadtime_edge_enable_reg    <= req.wdata;
      if (wr_mb)  out_mode_reg                <= req.wdata[7:PDT_MODE_LSB];
      if (wr_opt) option_reg                  <= req.wdata[1:0];
      if (wr_ien) irq_enable_reg              <= req.wdata[1:0];
      brake_flag_reg <= brake_flag_next;
      brake_prev_reg <= i_brake_pin;
      irq_status_reg <= irq_status_next;
      rdata_reg      <= req.rd ? rd_mux : 8'h00;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_irq   = |(irq_status_reg & irq_enable_reg);

  // ---------------------------------------------------------------------------
  // Dead-time datapath
  // ---------------------------------------------------------------------------
  logic                 dt_tick;
  logic [PDT_CHANS-1:0] pair_out;

  pdt_prescaler u_presc (
    .i_mclk (i_mclk),
    .i_rst  (i_rst),
    .i_sel  (deadtime_prescale_count_reg.presc_sel),
    .o_tick (dt_tick)
  );

  genvar g;
  generate
    for (g = 0; g < PDT_PAIRS; g++) begin : g_pair
      pdt_pair u_pair (
        .i_mclk      (i_mclk),
        .i_rst       (i_rst),
        .i_tick      (dt_tick),
        .i_active    (dt_on[g]),
        .i_edge_fall (deadtime_edge_enable_reg.edge_fall[g]),
        .i_count     (deadtime_prescale_count_reg.dt_count),
        .i_cmp       (i_pwm_cmp[2*g]),
        .o_even      (pair_out[2*g]),
        .o_odd       (pair_out[2*g+1])
      );
    end
  endgenerate

  // Non-complementary pairs pass channels straight; registered for clean data
  logic [PDT_CHANS-1:0] chan_reg;
  wire  [PDT_CHANS-1:0] compl_mask = {{2{i_pair_compl[3]}}, {2{i_pair_compl[2]}},
                                      {2{i_pair_compl[1]}}, {2{i_pair_compl[0]}}};
  always_ff @(posedge i_mclk) begin
    if (i_rst) chan_reg <= '0;
    else       chan_reg <= i_pwm_cmp;
  end
  wire [PDT_CHANS-1:0] chan_src = (compl_mask & pair_out) | (~compl_mask & chan_reg);

  // ---------------------------------------------------------------------------
  // Pin structure
  // ---------------------------------------------------------------------------
  // Per-channel mode enable from grouped bits
  wire [PDT_CHANS-1:0] mode_en = {out_mode_reg[0], out_mode_reg[1],
                                  out_mode_reg[2], out_mode_reg[3],
                                  out_mode_reg[2], out_mode_reg[3],
                                  out_mode_reg[2], out_mode_reg[3]};
  wire [PDT_CHANS-1:0] opt_en  = {4{option_reg[1], option_reg[0]}};   // 1 = quasi-bidirectional with pull-up, 0 = push-pull
  wire [PDT_CHANS-1:0] ext_val = i_ext_data_out ? i_ext_addr_out : i_ext_addr_out;

  wire [PDT_CHANS-1:0] pp      = mode_en & ~opt_en;
  wire [PDT_CHANS-1:0] quasi   = mode_en & opt_en;
  wire [PDT_CHANS-1:0] io_val  = i_port_latch_bit;
  wire [PDT_CHANS-1:0] pwm_sel = pp & ~i_port_latch_bit;

  // Quasi pins drive only a low; a high is left to the pull-up
  assign o_pin_out    = i_ext_exec ? ext_val :
                        ((pwm_sel & chan_src) | (~pwm_sel & io_val));
  assign o_pin_oe     = i_ext_exec ? {PDT_CHANS{1'b1}} :
                        (pp | (quasi & ~io_val));
  assign o_pin_pullup = i_ext_exec ? '0 : quasi;
  assign o_pin_strong = i_ext_exec ? ~opt_en : '0;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  brake_set_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_brake_pin |=> brake_flag_reg)
    else $error("brake flag not set by pin");
  brake_hold_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    brake_flag_reg && !(wr_mb && !req.wdata[0]) |=> brake_flag_reg)
    else $error("brake flag lost without clear");
  reserved_zero_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    req.rd && hit(req, PDT_OUT_MODE_BRAKE_ADDR) |=> o_rdata[3:1] == 3'b000)
    else $error("reserved bits not zero");
  reset_clear_a: assert property (@(posedge i_mclk)
    $past(i_rst) |-> out_mode_reg == 4'h0 && deadtime_edge_enable_reg == 8'h00)
    else $error("reset did not clear mode or edge bits");
  tristate_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    !i_ext_exec && !out_mode_reg[3] |-> !o_pin_oe[0] && !o_pin_oe[2] && !o_pin_oe[4])
    else $error("even group drives while disabled");
  odd_gate_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    !i_ext_exec && !out_mode_reg[2] |-> !o_pin_oe[1] && !o_pin_oe[3] && !o_pin_oe[5])
    else $error("odd group drives while disabled");
  single_gate_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    !i_ext_exec |-> (!o_pin_oe[6] || out_mode_reg[1]) && (!o_pin_oe[7] || out_mode_reg[0]))
    else $error("single channel drives while disabled");
  ext_pp_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_ext_exec |-> &o_pin_oe)
    else $error("external access not push-pull");
  ext_value_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_ext_exec |-> o_pin_out == i_ext_addr_out && o_pin_strong == ~opt_en)
    else $error("external access value or drive wrong");
  pwm_route_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    !i_ext_exec && out_mode_reg[0] && !option_reg[1] && !i_port_latch_bit[7]
      |-> o_pin_oe[7] && o_pin_out[7] == chan_src[7])
    else $error("pwm channel seven not routed");
  quasi_low_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    !i_ext_exec |-> (o_pin_oe & o_pin_pullup & o_pin_out) == '0)
    else $error("quasi pin drives high");
  mode_write_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    wr_mb |=> {out_mode_reg, 4'h0} == ($past(i_wdata) & 8'hF0))
    else $error("mode bits not written");
  edge_write_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    wr_ee |=> deadtime_edge_enable_reg == $past(i_wdata))
    else $error("edge and enable bits not written");
  compl_pair_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_pair_compl[0] && !dt_on[0] |=> pair_out[1] == !pair_out[0])
    else $error("inactive pair not complementary");

  cov_brake_c:  cover property (@(posedge i_mclk) disable iff (i_rst) brake_evt ##1 o_irq);
  cov_dt_c:     cover property (@(posedge i_mclk) disable iff (i_rst) dt_on[0] && i_pwm_cmp[0] ##5 pair_out[0]);
  cov_quasi_c:  cover property (@(posedge i_mclk) disable iff (i_rst) o_pin_pullup[1]);
  cov_ext_c:    cover property (@(posedge i_mclk) disable iff (i_rst) i_ext_exec && |o_pin_strong);
  cov_slow_c:   cover property (@(posedge i_mclk) disable iff (i_rst)
    deadtime_prescale_count_reg.presc_sel == 2'b11 && dt_tick);

endmodule : pdt_top

// >>> test/pdt_load.sv
// Load model: power stage seen from the pins, with its brake pin
`timescale 1ns/1ps
module pdt_load (
  // Clock
  input  wire logic       i_mclk,
  // Pins from the block
  input  wire logic [7:0] i_pin_out,
  input  wire logic [7:0] i_pin_oe,
  input  wire logic [7:0] i_pin_pullup,
  // Fault command from the bench
  input  wire logic       i_brake_req,
  // Levels and brake seen by the block
  output logic      [7:0] o_level,
  output logic            o_brake_pin
);
  logic [7:0] last_q = 8'h00;

  // Floating pins without pull-up never keep a stable level
  always_ff @(posedge i_mclk) begin
    last_q <= o_level;
  end
  assign o_level = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_pin_pullup)
                 | (~i_pin_oe & ~i_pin_pullup & ~last_q);
  assign o_brake_pin = i_brake_req;
endmodule : pdt_load

// >>> test/tb_top.sv
// Testbench: registers, pin gating, dead time and brake flag against a bench model
`timescale 1ns/1ps
module tb_top;
  import pdt_pkg::*;
  logic       i_mclk, i_rst, i_wr, i_rd, i_ext_exec, i_ext_data_out, brk_req, brk, o_irq;
  logic [7:0] i_addr, i_wdata, i_pwm_cmp, i_ext_addr_out, i_port_latch_bit;
  logic [7:0] o_rdata, o_pin_out, o_pin_oe, o_pin_pullup, o_pin_strong, lvl;
  logic [7:0] rv, opt, eoe, eout, epu, est;
  logic [3:0] i_pair_compl;
  int         miscompares, n_tests, cyc, rnd;

  pdt_top DUT (.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_pwm_cmp(i_pwm_cmp), .i_pair_compl(i_pair_compl),
    .i_ext_exec(i_ext_exec), .i_ext_data_out(i_ext_data_out), .i_ext_addr_out(i_ext_addr_out),
    .i_port_latch_bit(i_port_latch_bit), .i_brake_pin(brk), .o_pin_out(o_pin_out),
    .o_pin_oe(o_pin_oe), .o_pin_pullup(o_pin_pullup), .o_pin_strong(o_pin_strong), .o_irq(o_irq));
  pdt_load u_load (.i_mclk(i_mclk), .i_pin_out(o_pin_out), .i_pin_oe(o_pin_oe),
    .i_pin_pullup(o_pin_pullup), .i_brake_req(brk_req), .o_level(lvl), .o_brake_pin(brk));

  // ---------------------------------------------------------------------------
  // Bench tasks
  // ---------------------------------------------------------------------------
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_mclk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd   <= 1'b0;
    #1;
    d = o_rdata;
  endtask : rd

  // Mode nibble: bit 3 even group, bit 2 odd group, bit 1 channel 6, bit 0 channel 7
  function automatic logic gate(input logic [3:0] m, input int ch);
    return (ch == 6) ? m[1] : (ch == 7) ? m[0] : m[3 - (ch & 1)];
  endfunction : gate

  // Count cycles until the delayed output of pair g rises; expect (count+1) ticks
  task automatic dt_meas(input int g, input int sel, input logic fall);
    int p;
    int d;
    int n;
    p = 2 << sel;
    d = (sel + 1) * p;
    wr(PDT_PRESCALE_COUNT_ADDR, {sel[1:0], 6'(sel)});
    wr(PDT_EDGE_ENABLE_ADDR, 8'(1 << g) | (fall ? 8'(16 << g) : 8'h00));
    i_pwm_cmp[2*g] <= fall;
    repeat (60) @(posedge i_mclk);
    i_pwm_cmp[2*g] <= ~fall;
    n = 0;
    do begin
      @(posedge i_mclk);
      #1;
      n++;
      if (n == 2)
        chk(o_pin_out[2*g+int'(!fall)], 1'b0);
    end while (o_pin_out[2*g+int'(fall)] !== 1'b1 && n < 80);
    chk(8'(n > d - p && n <= d + 4), 8'h01);
  endtask : dt_meas

  // ---------------------------------------------------------------------------
  // Clock, timeout and main sequence
  // ---------------------------------------------------------------------------
  initial begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end

  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      close_out();
    end
  end

  initial begin
    {i_rst, i_wr, i_rd, i_ext_exec, i_ext_data_out, brk_req} = 6'b10_0000;
    {i_addr, i_wdata, i_pwm_cmp, i_ext_addr_out, i_port_latch_bit} = '0;
    i_pair_compl = 4'h0;
    rnd = $urandom(32'h0000_ad51);
    repeat (12) @(posedge i_mclk);
    i_rst <= 1'b0;
    #1;
    chk(o_pin_oe, 8'h00);
    rd(PDT_EDGE_ENABLE_ADDR, rv);
    chk(rv, PDT_EDGE_ENABLE_RST);
    rd(PDT_OUT_MODE_BRAKE_ADDR, rv);
    chk(rv, 8'h00);
    rd(8'hA0, rv);
    chk(rv, 8'h00);
    // Every output-mode pattern with random option, latch and comparator levels
    for (int m = 0; m < 16; m++) begin
      opt = 8'($urandom_range(0, 3));
      wr(PDT_OPTION_ADDR, opt);
      wr(PDT_OUT_MODE_BRAKE_ADDR, {m[3:0], 4'h0} | 8'($urandom_range(0, 15) & 14));
      i_pwm_cmp        <= 8'($urandom);
      i_port_latch_bit <= 8'($urandom);
      rd(PDT_OUT_MODE_BRAKE_ADDR, rv);
      chk(rv, {m[3:0], 4'h0});
      for (int ch = 0; ch < 8; ch++) begin
        eoe[ch]  = gate(m[3:0], ch) & (opt[ch & 1] ? ~i_port_latch_bit[ch] : 1'b1);
        eout[ch] = i_port_latch_bit[ch] | (~opt[ch & 1] & i_pwm_cmp[ch]);
        epu[ch]  = gate(m[3:0], ch) & opt[ch & 1];
        est[ch]  = ~opt[ch & 1];
      end
      chk(o_pin_oe, eoe);
      chk(o_pin_out & eoe, eout & eoe);
      chk(o_pin_pullup, epu);
      chk(lvl & epu, i_port_latch_bit & epu);
      i_ext_exec     <= 1'b1;
      i_ext_addr_out <= 8'($urandom);
      @(posedge i_mclk);
      #1;
      chk(o_pin_oe, 8'hFF);
      chk(o_pin_out, i_ext_addr_out);
      chk(o_pin_strong, est);
      @(posedge i_mclk);
      i_ext_exec <= 1'b0;
    end
    // Pairs with insertion inactive: complementary, or plain when not complementary
    wr(PDT_OPTION_ADDR, 8'h00);
    wr(PDT_OUT_MODE_BRAKE_ADDR, 8'hF0);
    i_port_latch_bit <= 8'h00;
    for (int k = 0; k < 2; k++) begin
      wr(PDT_EDGE_ENABLE_ADDR, k ? 8'h0F : 8'h00);
      i_pair_compl <= k ? 4'h0 : 4'hF;
      i_pwm_cmp    <= 8'($urandom);
      repeat (3) @(posedge i_mclk);
      #1;
      for (int g = 0; g < 4; g++)
        eout[2*g +: 2] = {k ? i_pwm_cmp[2*g+1] : ~i_pwm_cmp[2*g], i_pwm_cmp[2*g]};
      chk(o_pin_out, eout);
    end
    // Dead time on each pair, every prescaler code, both edges
    @(posedge i_mclk);
    i_pair_compl <= 4'hF;
    for (int s = 0; s < 4; s++) begin
      dt_meas(s, s, 1'b0);
      dt_meas(3 - s, s, 1'b1);
    end
    rd(PDT_IRQ_STATUS_ADDR, rv);
    chk(rv & 8'h02, 8'h02);
    // Brake: sticky flag, set wins over clear, interrupt enable and clear
    wr(PDT_IRQ_CLEAR_ADDR, 8'hFF);
    wr(PDT_IRQ_ENABLE_ADDR, 8'h01);
    #1;
    chk(o_irq, 1'b0);
    brk_req <= 1'b1;
    wr(PDT_OUT_MODE_BRAKE_ADDR, 8'hF0);
    rd(PDT_OUT_MODE_BRAKE_ADDR, rv);
    chk(rv, 8'hF1);
    brk_req <= 1'b0;
    repeat (3) @(posedge i_mclk);
    #1;
    chk(o_irq, 1'b1);
    rd(PDT_OUT_MODE_BRAKE_ADDR, rv);
    chk(rv, 8'hF1);
    rd(PDT_IRQ_STATUS_ADDR, rv);
    chk(rv, 8'h01);
    wr(PDT_IRQ_ENABLE_ADDR, 8'h00);
    #1;
    chk(o_irq, 1'b0);
    wr(PDT_IRQ_ENABLE_ADDR, 8'h01);
    wr(PDT_IRQ_CLEAR_ADDR, 8'h01);
    wr(PDT_OUT_MODE_BRAKE_ADDR, 8'hF0);
    #1;
    chk(o_irq, 1'b0);
    rd(PDT_OUT_MODE_BRAKE_ADDR, rv);
    chk(rv, 8'hF0);
    rd(PDT_IRQ_CLEAR_ADDR, rv);
    chk(rv, 8'h00);
    close_out();
  end
endmodule : tb_top
